// *** hdl/crc_pkg.sv ***
package crc_pkg;
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL   = 6'h00;
	localparam logic [5:0] OFS_LIMIT  = 6'h04;
	localparam logic [5:0] OFS_LOAD   = 6'h08;
	localparam logic [5:0] OFS_CMP    = 6'h0C;
	localparam logic [5:0] OFS_PDUR   = 6'h10;
	localparam logic [5:0] OFS_COUNT  = 6'h14;
	localparam logic [5:0] OFS_STATUS = 6'h18;
	localparam logic [5:0] OFS_ISTAT  = 6'h1C;
	localparam logic [5:0] OFS_IMASK  = 6'h20;
	localparam int         ADDR_W     = 6;
	localparam int         CNT_W      = 32;
	localparam int         PDUR_W     = 9;
	localparam int         IRQ_W      = 3;

	// CTRL fields
	localparam int CTRL_RNG   = 0;
	localparam int CTRL_CHR   = 2;
	localparam int CTRL_MDIR  = 4;
	localparam int CTRL_CONT  = 6;
	localparam int CTRL_ISEL  = 7;
	localparam int CTRL_EN    = 9;
	localparam int CTRL_LOAD  = 10;
	// STATUS fields
	localparam int STS_OUT    = 0;
	localparam int STS_UP     = 1;
	localparam int STS_ERR    = 2;
	// Interrupt status fields
	localparam int IRQ_WRAP_UP = 0;
	localparam int IRQ_WRAP_DN = 1;
	localparam int IRQ_CMP     = 2;

	// Reset values and limits
	localparam logic [31:0] LIMIT_MIN   = 32'h0000_0002;
	localparam logic [31:0] LIMIT_MAX   = 32'h7FFF_FFFF;
	localparam logic [31:0] LIMIT_RST   = 32'h7FFF_FFFF;
	localparam logic [31:0] ZERO_W      = 32'h0000_0000;
	localparam logic [31:0] ONE_W       = 32'h0000_0001;
	localparam logic [8:0]  PDUR_MAX    = 9'h1FE;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Pulse time base: one unit of pulse duration
	localparam int PULSE_UNIT_NS  = 1024000;
	localparam int CLK_PERIOD_NS  = 50;
	localparam int PULSE_UNIT_CYC = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		RNG_NONE = 2'b00,
		RNG_UP   = 2'b01,
		RNG_DOWN = 2'b10
	} crc_range_t;

	typedef enum logic [1:0] {
		CHR_NONE  = 2'b00,
		CHR_GE    = 2'b01,
		CHR_LE    = 2'b10,
		CHR_PULSE = 2'b11
	} crc_char_t;

	typedef enum logic [1:0] {
		MDIR_NONE = 2'b00,
		MDIR_UP   = 2'b01,
		MDIR_DOWN = 2'b10
	} crc_dir_t;

	typedef enum logic [1:0] {
		ISEL_NONE = 2'b00,
		ISEL_PROC = 2'b01,
		ISEL_DIAG = 2'b10
	} crc_isel_t;
endpackage : crc_pkg

// *** hdl/crc_pulse.sv ***
`timescale 1ns/1ps
module crc_pulse #(
	parameter int UNIT_CYC = crc_pkg::PULSE_UNIT_CYC,
	parameter int DUR_W    = crc_pkg::PDUR_W
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Trigger and length in units
	input  wire logic             fire,
	input  wire logic [DUR_W-1:0] dur,
	// Pulse
	output logic                  active
);
	localparam int                UW    = $clog2(UNIT_CYC + 1);
	localparam logic [UW-1:0]     U_TOP = UW'(UNIT_CYC - 1);
	localparam logic [DUR_W-1:0]  D_ONE = DUR_W'(1);

	typedef struct packed {
		logic [UW-1:0]    unit;
		logic [DUR_W-1:0] left;
		logic             act;
	} crc_pulse_state_t;

	crc_pulse_state_t s_q;
	crc_pulse_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (fire) begin
			// Retrigger restarts the full length
			s_d.unit = U_TOP;
			s_d.left = dur;
			s_d.act  = (dur != '0);
		end else if (s_q.act) begin
			if (s_q.unit == '0) begin
				s_d.unit = U_TOP;
				s_d.left = s_q.left - D_ONE;
				if (s_q.left == D_ONE) begin
					s_d.act = 1'b0;
				end
			end else begin
				s_d.unit = s_q.unit - UW'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign active = s_q.act;
endmodule : crc_pulse

// *** hdl/crc_counter.sv ***
`timescale 1ns/1ps
module crc_counter #(
	parameter int PULSE_UNIT_CYC = crc_pkg::PULSE_UNIT_CYC,
	parameter int AW             = crc_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Write address
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	// Write data
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	// Write response
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	output logic [1:0]         s_axi_bresp,
	// Read address
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	// Read data
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	// Count pulses from signal evaluation
	input  wire logic          cnt_up,
	input  wire logic          cnt_dn,
	// Output channel
	output logic               out_level,
	output logic               out_owned,
	// Interrupt
	output logic               irq
);
	localparam int W  = crc_pkg::CNT_W;
	localparam int IW = crc_pkg::IRQ_W;

	typedef struct packed {
		logic                aw_v;
		logic [AW-1:0]       aw_a;
		logic                w_v;
		logic [31:0]         w_d;
		logic [3:0]          w_s;
		logic                b_v;
		logic [1:0]          b_r;
		logic                r_v;
		logic [31:0]         r_d;
		logic [1:0]          r_r;
		crc_pkg::crc_range_t rng;
		crc_pkg::crc_char_t  chr;
		crc_pkg::crc_dir_t   mdir;
		logic                cont;
		crc_pkg::crc_isel_t  isel;
		logic                en;
		logic [W-1:0]        lim;
		logic [W-1:0]        ld;
		logic [W-1:0]        cmp;
		logic [8:0]          pdur;
		logic [W-1:0]        cnt;
		logic                up_last;
		logic                dir_ok;
		logic                err;
		logic [IW-1:0]       ist;
		logic [IW-1:0]       imsk;
		logic                out;
	} crc_state_t;

	crc_state_t s_q;
	crc_state_t s_d;
	logic       pulse_fire;
	logic       pulse_act;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] crc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : crc_merge

	// Address decode shared by read and write
	function automatic logic crc_mapped(input logic [AW-1:0] a);
		unique case (a)
			crc_pkg::OFS_CTRL, crc_pkg::OFS_LIMIT, crc_pkg::OFS_LOAD, crc_pkg::OFS_CMP,
			crc_pkg::OFS_PDUR, crc_pkg::OFS_COUNT, crc_pkg::OFS_STATUS, crc_pkg::OFS_ISTAT,
			crc_pkg::OFS_IMASK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : crc_mapped

	// Handshakes: one write and one read outstanding
	assign s_axi_awready = !s_q.aw_v && !s_q.b_v;
	assign s_axi_wready  = !s_q.w_v && !s_q.b_v;
	assign s_axi_arready = !s_q.r_v;
	assign s_axi_bvalid  = s_q.b_v;
	assign s_axi_bresp   = s_q.b_r;
	assign s_axi_rvalid  = s_q.r_v;
	assign s_axi_rdata   = s_q.r_d;
	assign s_axi_rresp   = s_q.r_r;

	always_comb begin
		logic          inc;
		logic          dec;
		logic          do_wr;
		logic          do_load;
		logic [31:0]   wv;
		logic [31:0]   cur;
		logic [IW-1:0] ev;
		logic [IW-1:0] clr;
		logic          hit;
		logic          ok;
		crc_pkg::crc_range_t nr;
		inc        = 1'b0;
		dec        = 1'b0;
		do_wr      = 1'b0;
		do_load    = 1'b0;
		wv         = '0;
		cur        = '0;
		ev         = '0;
		clr        = '0;
		hit        = 1'b0;
		ok         = 1'b0;
		nr         = crc_pkg::RNG_NONE;
		pulse_fire = 1'b0;
		s_d        = s_q;

		// Write channel capture, either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_v = 1'b1;
			s_d.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_v = 1'b1;
			s_d.w_d = s_axi_wdata;
			s_d.w_s = s_axi_wstrb;
		end
		if (s_q.b_v && s_axi_bready) begin
			s_d.b_v = 1'b0;
		end

		// Register write
		if (s_q.aw_v && s_q.w_v && !s_q.b_v) begin
			do_wr    = 1'b1;
			s_d.aw_v = 1'b0;
			s_d.w_v  = 1'b0;
			s_d.b_v  = 1'b1;
			s_d.b_r  = crc_mapped(s_q.aw_a) ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
		end
		if (do_wr) begin
			unique case (s_q.aw_a)
				crc_pkg::OFS_CTRL: begin
					cur = '0;
					cur[crc_pkg::CTRL_RNG +: 2]  = s_q.rng;
					cur[crc_pkg::CTRL_CHR +: 2]  = s_q.chr;
					cur[crc_pkg::CTRL_MDIR +: 2] = s_q.mdir;
					cur[crc_pkg::CTRL_CONT]      = s_q.cont;
					cur[crc_pkg::CTRL_ISEL +: 2] = s_q.isel;
					cur[crc_pkg::CTRL_EN]        = s_q.en;
					wv = crc_merge(cur, s_q.w_d, s_q.w_s);
					nr = crc_pkg::crc_range_t'(wv[crc_pkg::CTRL_RNG +: 2]);
					// Down with continuous counting is refused whole
					if ((wv[crc_pkg::CTRL_CONT] && nr == crc_pkg::RNG_DOWN)
						|| wv[crc_pkg::CTRL_RNG +: 2] == 2'b11) begin
						s_d.err = 1'b1;
					end else begin
						s_d.err  = 1'b0;
						s_d.rng  = nr;
						s_d.chr  = crc_pkg::crc_char_t'(wv[crc_pkg::CTRL_CHR +: 2]);
						s_d.mdir = crc_pkg::crc_dir_t'(wv[crc_pkg::CTRL_MDIR +: 2]);
						s_d.cont = wv[crc_pkg::CTRL_CONT];
						s_d.isel = crc_pkg::crc_isel_t'(wv[crc_pkg::CTRL_ISEL +: 2]);
						s_d.en   = wv[crc_pkg::CTRL_EN];
						do_load  = wv[crc_pkg::CTRL_LOAD];
					end
				end
				crc_pkg::OFS_LIMIT: begin
					wv = crc_merge(s_q.lim, s_q.w_d, s_q.w_s);
					if (wv < crc_pkg::LIMIT_MIN || wv > crc_pkg::LIMIT_MAX) begin
						s_d.err = 1'b1;
					end else begin
						s_d.err = 1'b0;
						s_d.lim = wv;
					end
				end
				crc_pkg::OFS_LOAD: begin
					s_d.ld = crc_merge(s_q.ld, s_q.w_d, s_q.w_s);
				end
				crc_pkg::OFS_CMP: begin
					s_d.cmp = crc_merge(s_q.cmp, s_q.w_d, s_q.w_s);
				end
				crc_pkg::OFS_PDUR: begin
					wv = crc_merge({23'h00_0000, s_q.pdur}, s_q.w_d, s_q.w_s);
					// Only even values exist; odd rounds down
					s_d.pdur = (wv[8:0] > crc_pkg::PDUR_MAX) ? crc_pkg::PDUR_MAX : {wv[8:1], 1'b0};
				end
				crc_pkg::OFS_ISTAT: begin
					clr = s_q.w_s[0] ? s_q.w_d[IW-1:0] : '0;
				end
				crc_pkg::OFS_IMASK: begin
					if (s_q.w_s[0]) begin
						s_d.imsk = s_q.w_d[IW-1:0];
					end
				end
				default: begin
					wv = '0;
				end
			endcase
		end

		// Counting
		inc = cnt_up && !cnt_dn && s_q.en;
		dec = cnt_dn && !cnt_up && s_q.en;
		if (do_load) begin
			s_d.cnt = s_q.ld;
		end else if (inc) begin
			s_d.up_last = 1'b1;
			if (s_q.rng == crc_pkg::RNG_UP
				&& $signed(s_q.cnt) >= $signed(s_q.lim - crc_pkg::ONE_W)) begin
				s_d.cnt = s_q.ld;
				ev[crc_pkg::IRQ_WRAP_UP] = 1'b1;
			end else begin
				// Free counting rolls over in two's complement
				s_d.cnt = s_q.cnt + crc_pkg::ONE_W;
			end
		end else if (dec) begin
			s_d.up_last = 1'b0;
			if (s_q.rng == crc_pkg::RNG_DOWN
				&& $signed(s_q.cnt) <= $signed(crc_pkg::ONE_W)) begin
				s_d.cnt = s_q.lim;
				ev[crc_pkg::IRQ_WRAP_DN] = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - crc_pkg::ONE_W;
			end
		end

		// Comparison reached, checked against direction
		hit = (s_d.cnt == s_q.cmp) && (s_d.cnt != s_q.cnt);
		unique case (s_q.mdir)
			crc_pkg::MDIR_UP:   ok = inc;
			crc_pkg::MDIR_DOWN: ok = dec;
			default:            ok = 1'b1;
		endcase
		if (hit) begin
			s_d.dir_ok = ok;
			ev[crc_pkg::IRQ_CMP] = ok;
		end
		pulse_fire = hit && ok && s_q.chr == crc_pkg::CHR_PULSE;

		// Output channel
		unique case (s_q.chr)
			crc_pkg::CHR_GE:    s_d.out = $signed(s_q.cnt) >= $signed(s_q.cmp);
			crc_pkg::CHR_LE:    s_d.out = $signed(s_q.cnt) <= $signed(s_q.cmp);
			crc_pkg::CHR_PULSE: begin
				if (s_q.pdur == '0) begin
					s_d.out = (s_q.cnt == s_q.cmp) && s_q.dir_ok;
				end else begin
					s_d.out = pulse_act;
				end
			end
			default:            s_d.out = 1'b0;
		endcase

		// Sticky events; a set in the clear cycle wins
		if (s_q.isel == crc_pkg::ISEL_NONE) begin
			ev = '0;
		end
		s_d.ist = (s_q.ist & ~clr) | ev;

		// Read channel
		if (s_q.r_v && s_axi_rready) begin
			s_d.r_v = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.r_v = 1'b1;
			s_d.r_r = crc_mapped(s_axi_araddr) ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
			s_d.r_d = '0;
			unique case (s_axi_araddr)
				crc_pkg::OFS_CTRL: begin
					s_d.r_d[crc_pkg::CTRL_RNG +: 2]  = s_q.rng;
					s_d.r_d[crc_pkg::CTRL_CHR +: 2]  = s_q.chr;
					s_d.r_d[crc_pkg::CTRL_MDIR +: 2] = s_q.mdir;
					s_d.r_d[crc_pkg::CTRL_CONT]      = s_q.cont;
					s_d.r_d[crc_pkg::CTRL_ISEL +: 2] = s_q.isel;
					s_d.r_d[crc_pkg::CTRL_EN]        = s_q.en;
				end
				crc_pkg::OFS_LIMIT:  s_d.r_d = s_q.lim;
				crc_pkg::OFS_LOAD:   s_d.r_d = s_q.ld;
				crc_pkg::OFS_CMP:    s_d.r_d = s_q.cmp;
				crc_pkg::OFS_PDUR:   s_d.r_d[8:0] = s_q.pdur;
				crc_pkg::OFS_COUNT:  s_d.r_d = s_q.cnt;
				crc_pkg::OFS_STATUS: begin
					s_d.r_d[crc_pkg::STS_OUT] = s_q.out;
					s_d.r_d[crc_pkg::STS_UP]  = s_q.up_last;
					s_d.r_d[crc_pkg::STS_ERR] = s_q.err;
				end
				crc_pkg::OFS_ISTAT:  s_d.r_d[IW-1:0] = s_q.ist;
				crc_pkg::OFS_IMASK:  s_d.r_d[IW-1:0] = s_q.imsk;
				default:             s_d.r_d = crc_pkg::ZERO_W;
			endcase
		end
	end

	crc_pulse #(
		.UNIT_CYC (PULSE_UNIT_CYC),
		.DUR_W    (crc_pkg::PDUR_W)
	) u_pulse (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fire    (pulse_fire),
		.dur     (s_q.pdur),
		.active  (pulse_act)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q      <= '0;
			s_q.lim  <= crc_pkg::LIMIT_RST;
			s_q.rng  <= crc_pkg::RNG_NONE;
			s_q.chr  <= crc_pkg::CHR_NONE;
			s_q.mdir <= crc_pkg::MDIR_NONE;
			s_q.isel <= crc_pkg::ISEL_NONE;
		end else begin
			s_q <= s_d;
		end
	end

	// Ownership is a plain decode; the level is registered
	assign out_owned = (s_q.chr != crc_pkg::CHR_NONE);
	assign out_level = s_q.out;
	assign irq       = |(s_q.ist & s_q.imsk);
endmodule : crc_counter

// *** sim/crc_counter_monitor.sv ***
`timescale 1ns/1ps
module crc_counter_monitor (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Counting and output
	input wire logic        cnt_up,
	input wire logic        cnt_dn,
	input wire logic        out_level,
	input wire logic        out_owned,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	b_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during read data");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	out_free_a: assert property (!out_owned [*3] |-> !out_level)
		else $error("output driven without comparison");
	owned_write_a: assert property ($changed(out_owned) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("output ownership changed without write");
	irq_cause_a: assert property ($rose(irq) |->
		$past(cnt_up || cnt_dn) || s_axi_bvalid || $past(s_axi_bvalid))
		else $error("interrupt without cause");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(irq));
	cover property ($fell(out_level));
endmodule : crc_counter_monitor

bind crc_counter crc_counter_monitor i_crc_counter_monitor (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.cnt_up, .cnt_dn, .out_level, .out_owned, .irq);

// *** sim/crc_src.sv ***
`timescale 1ns/1ps
module crc_src (
	// Clock and command
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic       up,
	input  wire logic [7:0] n,
	input  wire logic       slow,
	// Count pulses
	output logic            cnt_up = 1'b0,
	output logic            cnt_dn = 1'b0,
	output logic            idle
);
	logic [7:0] left = 8'h00;
	logic [1:0] gap  = 2'h0;
	logic       dir  = 1'b0;
	// One-cycle pulses, never both lines at once
	always @(posedge aclk) begin
		cnt_up <= 1'b0;
		cnt_dn <= 1'b0;
		if (go) begin
			left <= n;
			dir  <= up;
			gap  <= 2'h0;
		end else if (left != 8'h00 && gap == 2'h0) begin
			cnt_up <= dir;
			cnt_dn <= !dir;
			left   <= left - 8'h01;
			gap    <= slow ? 2'h3 : 2'h0;
		end else if (gap != 2'h0) begin
			gap <= gap - 2'h1;
		end
	end
	assign idle = left == 8'h00 && !cnt_up && !cnt_dn;
endmodule : crc_src

// *** sim/crc_counter_bench.sv ***
`timescale 1ns/1ps
module crc_counter_bench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        out_level, out_owned, irq, cnt_up, cnt_dn, go, gup, gsl, idl;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  gn;
	int          err_total, total_checks;

	crc_counter #(.PULSE_UNIT_CYC(4)) i_crc_counter (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cnt_up, .cnt_dn,
		.out_level, .out_owned, .irq);
	crc_src i_crc_src (.aclk, .go, .up(gup), .n(gn), .slow(gsl), .cnt_up, .cnt_dn, .idle(idl));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	// Every wait is bounded
	task lim(input int n);
		if (n > 200) begin
			err_total++;
			print_verdict();
		end
	endtask : lim

	task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw, ha, hw;
		logic [1:0] r;
		int n;
		// Start on an edge so every drive lands on it
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		ha = 1'b0;
		hw = 1'b0;
		n = 0;
		do begin
			#1 ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			ha = ha | ta;
			hw = hw | tw;
			n++;
			lim(n);
		end while (!(ha && hw));
		do begin
			#1 ta = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			n++;
			lim(n);
		end while (!ta);
		s_axi_bready <= 1'b0;
		chk("bresp", r, e);
		@(posedge aclk);
		// Leave the launching edge so callers see settled outputs
		#1;
	endtask : wr

	task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		logic t;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			#1 t = s_axi_arready;
			@(posedge aclk);
			n++;
			lim(n);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			#1 t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			n++;
			lim(n);
		end while (!t);
		s_axi_rready <= 1'b0;
		chk("rdata", d, e);
		chk("rresp", r, er);
		@(posedge aclk);
		#1;
	endtask : rd

	// Pulses from the source, then room for the registered output
	task pls(input logic u, input logic [7:0] k, input logic s);
		logic t;
		int n;
		@(posedge aclk);
		go <= 1'b1;
		gup <= u;
		gn <= k;
		gsl <= s;
		@(posedge aclk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge aclk);
			#1 t = idl;
			n++;
			lim(n);
		end while (!t);
		repeat (3) @(posedge aclk);
		#1;
	endtask : pls

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go, gup, gsl} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, gn} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(6'h00, 32'h0000_0000, 2'h0);
		rd(6'h04, 32'h7FFF_FFFF, 2'h0);
		rd(6'h18, 32'h0000_0000, 2'h0);
		rd(6'h24, 32'h0000_0000, 2'h2);
		wr(6'h24, 32'h0000_0001, 2'h2);
		wr(6'h04, 32'h0000_0001, 2'h0);
		rd(6'h18, 32'h0000_0004, 2'h0);
		wr(6'h04, 32'h7FFF_FFFF, 2'h0);
		rd(6'h18, 32'h0000_0000, 2'h0);
		wr(6'h00, 32'h0000_0042, 2'h0);
		rd(6'h18, 32'h0000_0004, 2'h0);
		rd(6'h00, 32'h0000_0000, 2'h0);
		// Up range with greater-or-equal output
		wr(6'h04, 32'h0000_0005, 2'h0);
		wr(6'h08, 32'h0000_0003, 2'h0);
		wr(6'h0C, 32'h0000_0004, 2'h0);
		wr(6'h00, 32'h0000_0685, 2'h0);
		chk("owned", out_owned, 1'h1);
		pls(1'b1, 8'h01, 1'b0);
		chk("out", out_level, 1'h1);
		pls(1'b1, 8'h01, 1'b0);
		rd(6'h14, 32'h0000_0003, 2'h0);
		chk("out", out_level, 1'h0);
		rd(6'h1C, 32'h0000_0005, 2'h0);
		chk("irq", irq, 1'h0);
		wr(6'h20, 32'h0000_0001, 2'h0);
		chk("irq", irq, 1'h1);
		wr(6'h1C, 32'h0000_0005, 2'h0);
		chk("irq", irq, 1'h0);
		wr(6'h00, 32'h0000_0208, 2'h0);
		chk("out", out_level, 1'h1);
		// Down range, slow source
		wr(6'h04, 32'h0000_0003, 2'h0);
		wr(6'h08, 32'h0000_0002, 2'h0);
		wr(6'h00, 32'h0000_0682, 2'h0);
		pls(1'b0, 8'h02, 1'b1);
		rd(6'h14, 32'h0000_0003, 2'h0);
		rd(6'h1C, 32'h0000_0002, 2'h0);
		wr(6'h1C, 32'h0000_0002, 2'h0);
		// Free counting through zero
		wr(6'h08, 32'h0000_0000, 2'h0);
		wr(6'h00, 32'h0000_0680, 2'h0);
		pls(1'b0, 8'h01, 1'b0);
		rd(6'h14, 32'hFFFF_FFFF, 2'h0);
		pls(1'b1, 8'h02, 1'b0);
		rd(6'h1C, 32'h0000_0000, 2'h0);
		// Timed pulse, main direction up, no interrupt
		wr(6'h20, 32'h0000_0007, 2'h0);
		wr(6'h0C, 32'h0000_0002, 2'h0);
		wr(6'h10, 32'h0000_0002, 2'h0);
		wr(6'h00, 32'h0000_061C, 2'h0);
		pls(1'b1, 8'h02, 1'b0);
		chk("out", out_level, 1'h1);
		repeat (12) @(posedge aclk);
		#1;
		chk("out", out_level, 1'h0);
		rd(6'h1C, 32'h0000_0000, 2'h0);
		chk("irq", irq, 1'h0);
		pls(1'b1, 8'h01, 1'b0);
		pls(1'b0, 8'h01, 1'b0);
		chk("out", out_level, 1'h0);
		// Zero duration follows the compare
		wr(6'h10, 32'h0000_0000, 2'h0);
		wr(6'h00, 32'h0000_020C, 2'h0);
		pls(1'b1, 8'h01, 1'b0);
		pls(1'b0, 8'h01, 1'b0);
		repeat (20) @(posedge aclk);
		#1;
		chk("out", out_level, 1'h1);
		pls(1'b0, 8'h01, 1'b0);
		chk("out", out_level, 1'h0);
		wr(6'h00, 32'h0000_0200, 2'h0);
		chk("owned", out_owned, 1'h0);
		chk("out", out_level, 1'h0);
		print_verdict();
	end
endmodule : crc_counter_bench
